// ==== ppoc_pkg.sv ====
// package: constants and carrier types for port power and overcurrent control
package ppoc_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ       = 10000000;
  localparam int unsigned TICK_MS      = 1;                       // tick period in ms
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;  // cycles per tick
  // ****************************************************************
  // reset values and upper limit of the settings
  // ****************************************************************
  localparam logic [3:0] MIN_WIDTH_RST   = 4'h1;
  localparam logic [7:0] DBL_WINDOW_RST  = 8'h14;  // 20 ms
  localparam logic [7:0] LOCKOUT_RST     = 8'h0a;  // 10 ms
  localparam logic [3:0] MIN_WIDTH_MAX   = 4'h5;   // largest defined code
  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic [3:0] min_width;   // single pulse width, ms
    logic [7:0] dbl_window;  // double pulse window, ms
    logic [7:0] lockout;     // turn-on lockout, ms
  } ppoc_timing_t;

  typedef enum logic [1:0] {
    PPOC_OFF  = 2'b00,
    PPOC_LOCK = 2'b01,
    PPOC_RUN  = 2'b10
  } ppoc_state_t;
endpackage : ppoc_pkg

// ==== ppoc_ctrl.sv ====
// module: downstream port power control and overcurrent detection
// How it works
// R1: default individual mode, one pin per port handled independently.
// R2: ganged mode uses the shared pin to control and sense every port.
// R3: ganged overcurrent flags every downstream port together.
// R4: power off drives pin low and turns pull-up off.
// R5: power on releases driver, enables pull-up, open drain.
// R6: external switch pulls pin low on overcurrent.
// R7: powered pin sampled each cycle; lows are candidate overcurrent.
// R8: continuous low for the single-pulse width declares overcurrent.
// R9: two low groups within the double window declare overcurrent.
// R10: single width and double window are software settings.
// R11: lockout after power on ignores the pin level.
// R12: short lows are filtered before overcurrent is declared.
// R13: per-port charging indication on pins 6 to 1, configurable.
// R14: reset returns all settings to defaults and drops state.
// R15: single width is 4 bits in 1 ms steps, codes 0 to 5.
// R16: double window 8 bits in 1 ms, default 20 ms, never zero; cfg_load takes a 0 unchecked, and it acts like 1.
// R17: lockout 8 bits in 1 ms, default 10 ms, never zero; cfg_load takes a 0 unchecked, and it acts like 1.
// R18: a 1 ms tick from the core clock times all counters.
// R19: sticky per-port overcurrent flag, cleared by hub logic.
`timescale 1ns/10ps
module ppoc_ctrl #(
  parameter int unsigned NPORT       = 6,
  parameter int unsigned TICK_CYCLES = ppoc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // configuration
  input  wire logic                  cfg_load,      // pulse: take new settings
  input  wire ppoc_pkg::ppoc_timing_t cfg_timing,
  input  wire logic                  gang_mode,     // 1: shared pin for all ports
  input  wire logic [NPORT-1:0]      bc_enable,     // charging indication per port
  // hub side
  input  wire logic [NPORT-1:0]      port_power_on,
  input  wire logic [NPORT-1:0]      oc_clear,      // pulse per port
  output logic      [NPORT-1:0]      oc_flag,
  output logic      [NPORT-1:0]      bc_indicate,
  // port power sense pins
  input  wire logic [NPORT-1:0]      port_power_sense_pins_i,
  output logic      [NPORT-1:0]      port_power_sense_pins_o,
  output logic      [NPORT-1:0]      port_power_sense_pins_oe_n,
  output logic      [NPORT-1:0]      port_power_sense_pins_pu,
  // shared power pin
  input  wire logic                  shared_power_pin_i,
  output logic                       shared_power_pin_o,
  output logic                       shared_power_pin_oe_n,
  output logic                       shared_power_pin_pu
);
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  // ****************************************************************
  // settings
  // ****************************************************************
  ppoc_pkg::ppoc_timing_t timing_r;

  // settings take defaults on reset
  always_ff @(posedge clk) begin
    if (!nrst) begin // R14
      timing_r.min_width  <= ppoc_pkg::MIN_WIDTH_RST;
      timing_r.dbl_window <= ppoc_pkg::DBL_WINDOW_RST; // R16
      timing_r.lockout    <= ppoc_pkg::LOCKOUT_RST;    // R17
    end else if (cfg_load) begin // R10
      timing_r.min_width  <= (cfg_timing.min_width > ppoc_pkg::MIN_WIDTH_MAX) ?
                             ppoc_pkg::MIN_WIDTH_MAX : cfg_timing.min_width; // R15
      timing_r.dbl_window <= cfg_timing.dbl_window;
      timing_r.lockout    <= cfg_timing.lockout;
    end
  end

  // ****************************************************************
  // millisecond tick
  // ****************************************************************
  logic [TW-1:0] tick_cnt_r;
  logic          tick_r;

  // divider gives one-cycle pulse each ms
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == TW'(TICK_CYCLES - 1)) begin // R18
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r     <= 1'b0;
    end
  end

  // ****************************************************************
  // channel selection
  // ****************************************************************
  logic [NPORT-1:0] ch_power;
  logic [NPORT-1:0] ch_sense;
  logic [NPORT-1:0] ch_det;
  logic             gang_r;
  logic             mode_chg;

  // mode seen last cycle, to catch a switch of the sense source
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gang_r <= 1'b0;
    end else begin
      gang_r <= gang_mode;
    end
  end

  // a mode switch hands a running channel a pin that was driven low,
  // so every channel restarts through off and a fresh lockout
  assign mode_chg = gang_mode != gang_r; // R11

  // ganged uses channel 0 on the shared pin
  always_comb begin
    ch_power = port_power_on;
    ch_sense = port_power_sense_pins_i; // R1
    if (gang_mode) begin // R2
      ch_power    = '0;
      ch_power[0] = |port_power_on;
      ch_sense    = '1;
      ch_sense[0] = shared_power_pin_i;
    end
  end

  // ****************************************************************
  // per-channel detectors
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_ch
      ppoc_pkg::ppoc_state_t st_r;
      logic [7:0] lock_cnt_r;
      logic [3:0] low_ms_r;
      logic [7:0] win_cnt_r;
      logic       win_act_r;
      logic       prev_low_r;
      logic       low;
      logic       new_group;

      assign low       = (st_r == ppoc_pkg::PPOC_RUN) && !mode_chg && !ch_sense[g]; // R7
      assign new_group = low && !prev_low_r;

      // power, lockout and run sequencing
      always_ff @(posedge clk) begin
        if (!nrst || !ch_power[g] || mode_chg) begin // R11
          st_r       <= ppoc_pkg::PPOC_OFF;
          lock_cnt_r <= '0;
        end else begin
          unique case (st_r)
            ppoc_pkg::PPOC_OFF: begin
              st_r       <= ppoc_pkg::PPOC_LOCK;
              lock_cnt_r <= timing_r.lockout;
            end
            ppoc_pkg::PPOC_LOCK: begin
              if (lock_cnt_r <= 8'h01 && tick_r) // R11
                st_r <= ppoc_pkg::PPOC_RUN;
              else if (tick_r)
                lock_cnt_r <= lock_cnt_r - 8'h01;
            end
            ppoc_pkg::PPOC_RUN: st_r <= ppoc_pkg::PPOC_RUN;
            default: st_r <= ppoc_pkg::PPOC_OFF;
          endcase
        end
      end

      // single pulse width in whole ms of continuous low
      always_ff @(posedge clk) begin
        if (!nrst || !low) begin // R12
          low_ms_r <= '0;
        end else if (tick_r && low_ms_r != 4'hf) begin
          low_ms_r <= low_ms_r + 4'h1; // R8
        end
      end

      // rolling window opened by first low group
      always_ff @(posedge clk) begin
        if (!nrst || st_r != ppoc_pkg::PPOC_RUN) begin
          prev_low_r <= 1'b0;
          win_act_r  <= 1'b0;
          win_cnt_r  <= '0;
        end else begin
          prev_low_r <= low;
          if (new_group && !win_act_r) begin // R9
            win_act_r <= 1'b1;
            win_cnt_r <= timing_r.dbl_window;
          end else if (win_act_r && tick_r) begin
            if (win_cnt_r <= 8'h01)
              win_act_r <= 1'b0;
            win_cnt_r <= win_cnt_r - 8'h01;
          end
        end
      end

      assign ch_det[g] = (low && low_ms_r >= timing_r.min_width) // R8
                         || (new_group && win_act_r);            // R9
    end
  endgenerate

  // ****************************************************************
  // sticky flags and pin drive
  // ****************************************************************
  // set wins over clear; ganged detection sets all
  always_ff @(posedge clk) begin
    if (!nrst) begin
      oc_flag <= '0;
    end else begin
      oc_flag <= (oc_flag & ~oc_clear)
               | (gang_mode ? {NPORT{ch_det[0]}} : ch_det); // R3 R19
    end
  end

  // off drives low, pull-up off; on releases and pulls up
  always_ff @(posedge clk) begin
    if (!nrst) begin
      port_power_sense_pins_o    <= '0;
      port_power_sense_pins_oe_n <= '0;
      port_power_sense_pins_pu   <= '0;
      shared_power_pin_o         <= 1'b0;
      shared_power_pin_oe_n      <= 1'b0;
      shared_power_pin_pu        <= 1'b0;
      bc_indicate                <= '0;
    end else begin
      port_power_sense_pins_o    <= '0;
      port_power_sense_pins_oe_n <= gang_mode ? '0 : ch_power;  // R4 R5
      port_power_sense_pins_pu   <= gang_mode ? '0 : ch_power;  // R4 R5
      shared_power_pin_o         <= 1'b0;
      shared_power_pin_oe_n      <= gang_mode & ch_power[0];    // R4 R5
      shared_power_pin_pu        <= gang_mode & ch_power[0];
      bc_indicate                <= bc_enable & port_power_on;  // R13
    end
  end
endmodule : ppoc_ctrl

// ==== ppoc_ctrl_props.sv ====
// checker: pin drive, gang and flag relations of the port power block
`timescale 1ns/10ps
module ppoc_ctrl_props #(
  parameter int unsigned NPORT = 6
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             nrst,
  // watched ports
  input wire logic             gang_mode,
  input wire logic [NPORT-1:0] port_power_on,
  input wire logic [NPORT-1:0] oc_clear,
  input wire logic [NPORT-1:0] oc_flag,
  input wire logic [NPORT-1:0] port_power_sense_pins_oe_n,
  input wire logic [NPORT-1:0] port_power_sense_pins_pu,
  input wire logic             shared_power_pin_oe_n
);
  // all checks on the core clock, quiet in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_off_drive_low: assert property (!gang_mode && !port_power_on[0] |=>
    !port_power_sense_pins_oe_n[0] && !port_power_sense_pins_pu[0]) else $error("pin not low");
  chk_on_release: assert property (!gang_mode && port_power_on[0] |=>
    port_power_sense_pins_oe_n[0] && port_power_sense_pins_pu[0]) else $error("pin not free");
  chk_pull_follows: assert property (port_power_sense_pins_pu == port_power_sense_pins_oe_n)
    else $error("pull-up wrong");
  chk_gang_pins_low: assert property (gang_mode |=> port_power_sense_pins_oe_n == '0)
    else $error("gang pins free");
  chk_gang_shared: assert property (gang_mode |=>
    shared_power_pin_oe_n == $past(|port_power_on)) else $error("shared pin wrong");
  chk_gang_all_flag: assert property ($past(gang_mode) && $rose(oc_flag[0]) |-> &oc_flag)
    else $error("gang flags split");
  chk_flag_sticky: assert property (($past(oc_flag) & ~$past(oc_clear) & ~oc_flag) == '0)
    else $error("flag dropped");
  chk_flag_needs_power: assert property (!$past(gang_mode) |->
    (oc_flag & ~$past(oc_flag) & ~$past(port_power_on, 2)) == '0)
    else $error("flag while unpowered");
endmodule : ppoc_ctrl_props
bind ppoc_ctrl ppoc_ctrl_props #(.NPORT(NPORT)) u_props (
  .clk                        (clk),
  .nrst                       (nrst),
  .gang_mode                  (gang_mode),
  .port_power_on              (port_power_on),
  .oc_clear                   (oc_clear),
  .oc_flag                    (oc_flag),
  .port_power_sense_pins_oe_n (port_power_sense_pins_oe_n),
  .port_power_sense_pins_pu   (port_power_sense_pins_pu),
  .shared_power_pin_oe_n      (shared_power_pin_oe_n)
);

// ==== ppoc_sw_model.sv ====
// partner: power switch whose open-drain fault output shares each sense pin
`timescale 1ns/10ps
module ppoc_sw_model #(
  parameter int unsigned W = 1
) (
  // device drive and switch fault
  input  wire logic [W-1:0] o,
  input  wire logic [W-1:0] oe_n,
  input  wire logic [W-1:0] pu,
  input  wire logic [W-1:0] fault,  // high: switch pulls its pin low
  output logic      [W-1:0] pin
);
  // device drive first, then the fault pull-down, then the pull-up
  assign pin = (~oe_n & o) | (oe_n & ~fault & pu);
endmodule : ppoc_sw_model

// ==== tb_ppoc_ctrl.sv ====
// testbench: port power and overcurrent control with switch models
`timescale 1ns/10ps
module tb_ppoc_ctrl;
  localparam int unsigned TC = 10;  // cycles per ms in this run
  logic                   clk, nrst, cfg_load, gang_mode, shared_power_pin_i;
  logic                   shared_power_pin_o, shared_power_pin_oe_n, shared_power_pin_pu;
  ppoc_pkg::ppoc_timing_t cfg_timing;
  logic [5:0]             bc_enable, port_power_on, oc_clear, oc_flag, bc_indicate;
  logic [5:0]             port_power_sense_pins_i, port_power_sense_pins_o;
  logic [5:0]             port_power_sense_pins_oe_n, port_power_sense_pins_pu;
  logic [6:0]             flt;  // switch faults, bit 6 on the shared pin
  int                     n_fail = 0, compares = 0, cycles = 0, p, m;
  // design and one switch model per pin group
  ppoc_ctrl #(.NPORT(6), .TICK_CYCLES(TC)) DUT (
    .clk(clk), .nrst(nrst), .cfg_load(cfg_load), .cfg_timing(cfg_timing),
    .gang_mode(gang_mode), .bc_enable(bc_enable), .port_power_on(port_power_on),
    .oc_clear(oc_clear), .oc_flag(oc_flag), .bc_indicate(bc_indicate),
    .port_power_sense_pins_i(port_power_sense_pins_i),
    .port_power_sense_pins_o(port_power_sense_pins_o),
    .port_power_sense_pins_oe_n(port_power_sense_pins_oe_n),
    .port_power_sense_pins_pu(port_power_sense_pins_pu),
    .shared_power_pin_i(shared_power_pin_i), .shared_power_pin_o(shared_power_pin_o),
    .shared_power_pin_oe_n(shared_power_pin_oe_n), .shared_power_pin_pu(shared_power_pin_pu));
  ppoc_sw_model #(.W(6)) u_sw (.o(port_power_sense_pins_o), .oe_n(port_power_sense_pins_oe_n),
    .pu(port_power_sense_pins_pu), .fault(flt[5:0]), .pin(port_power_sense_pins_i));
  ppoc_sw_model #(.W(1)) u_gsw (.o(shared_power_pin_o), .oe_n(shared_power_pin_oe_n),
    .pu(shared_power_pin_pu), .fault(flt[6]), .pin(shared_power_pin_i));
  // clock and hang ceiling
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      finish_test();
    end
  end
  task cyc(input int n);  // n edges, then the drive delay
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task chk(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk
  task pulse(input int i, input int n);  // switch fault for n cycles
    flt[i] = 1'b1;
    cyc(n);
    flt[i] = 1'b0;
  endtask : pulse
  task load(input logic [3:0] w, input logic [7:0] d, input logic [7:0] l);
    cfg_timing = '{w, d, l};
    cfg_load = 1'b1;
    cyc(1);
    cfg_load = 1'b0;
  endtask : load
  task restart(input int lk);  // power cycle, clear flags, wait out lockout
    port_power_on = '0;
    oc_clear = '1;
    cyc(2);
    oc_clear = '0;
    port_power_on = '1;
    cyc(lk * TC + TC);
  endtask : restart
  task dflt();  // fault inside then after the reset-value lockout
    p = $urandom % 6;
    restart(0);
    cyc(4 * TC);
    pulse(p, 3 * TC);
    chk(oc_flag, 6'h00);
    cyc(7 * TC);
    pulse(p, 2 * TC + 2);
    cyc(2);
    chk(oc_flag, 6'h01 << p);
  endtask : dflt
  task finish_test();
    $display("counts: %0d mismatches in %0d compares", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  // main sequence
  initial begin
    {nrst, cfg_load, gang_mode, bc_enable, port_power_on, oc_clear, flt} = '0;
    cfg_timing = '0;
    p = $urandom(32'h0aeaf9e6);
    cyc(4);
    nrst = 1'b1;
    dflt();
    // every width code, short pulse filtered for codes 2 to 5, long one flagged
    for (int k = 0; k < 7; k++) begin
      m = (k == 6) ? 5 : k;
      bc_enable = 6'($urandom);
      load((k == 6) ? 4'hf : 4'(k), 8'h01, 8'h01);
      restart(1);
      chk(bc_indicate, bc_enable);
      chk(port_power_sense_pins_oe_n & port_power_sense_pins_pu, 6'h3f);
      p = $urandom % 6;
      if (m > 1) begin
        pulse(p, 1 + $urandom % (TC * m - TC - 1));
        cyc(3 * TC);
        chk(oc_flag, 6'h00);
      end
      pulse(p, (m == 0) ? 1 : m * TC + TC + $urandom % 20);
      cyc(2);
      chk(oc_flag, 6'h01 << p);
    end
    // two short lows inside, then outside, a random window
    m = 3 + $urandom % 6;
    load(4'h5, 8'(m), 8'h01);
    for (int k = 0; k < 2; k++) begin
      restart(1);
      pulse(p, 1);
      cyc(k ? TC * m + TC + 3 : TC * m - TC - 3);
      pulse(p, 1);
      cyc(2);
      chk(oc_flag, k ? 6'h00 : 6'h01 << p);
    end
    // ganged: shared pin powers and senses every port
    gang_mode = 1'b1;
    load(4'h1, 8'h14, 8'h01);
    chk(oc_flag, 6'h00);
    restart(1);
    chk({5'h00, shared_power_pin_oe_n}, 6'h01);
    chk({4'h0, shared_power_pin_pu, shared_power_pin_o}, 6'h02);
    chk(oc_flag, 6'h00);
    pulse(6, 2 * TC + 2);
    cyc(2);
    chk(oc_flag, 6'h3f);
    gang_mode = 1'b0;
    // reset in mid run drops flags and restores the settings
    port_power_on = '0;
    nrst = 1'b0;
    cyc(4);
    nrst = 1'b1;
    chk(oc_flag, 6'h00);
    chk(port_power_sense_pins_oe_n, 6'h00);
    chk(port_power_sense_pins_pu | port_power_sense_pins_o, 6'h00);
    dflt();
    finish_test();
  end
endmodule : tb_ppoc_ctrl
